// >>> verilog/wbc_pkg.sv
`default_nettype none
package wbc_pkg;
  localparam logic [7:0] WBC_ADDR_WIDTH = 8'h08;
  localparam logic [7:0] WBC_CONFIG_OFFSET = 8'h07;
  localparam logic [7:0] WBC_SECOND_OFFSET = 8'h06;
  localparam logic [7:0] WBC_CONFIG_RESET = 8'hBF;
  localparam logic [7:0] WBC_SECOND_RESET = 8'h4B;
  localparam int WBC_TEMP_MSB = 7;
  localparam int WBC_TEMP_LSB = 5;
  localparam int WBC_VOLT_MSB = 4;
  localparam int WBC_VOLT_LSB = 3;
  localparam int WBC_CURR_MSB = 2;
  localparam int WBC_CURR_LSB = 0;

  typedef struct packed {
    logic [2:0] third_temp_threshold_select;
    logic [1:0] mid_band_term_voltage_select;
    logic [2:0] mid_band_charge_current_select;
  } wbc_fields_t;

  typedef struct packed {
    logic signed [7:0] upper_temp_c;
    logic signed [7:0] lower_temp_c;
    logic [11:0] term_voltage_mv;
    logic [9:0] current_permille;
  } wbc_band_t;

  function automatic logic signed [7:0] wbc_temp_decode(input logic [2:0] code);
    logic signed [7:0] t;
    t = 8'sh00;
    case (code)
      3'h0: t = -8'sd10;
      3'h1: t = 8'sd0;
      3'h2: t = 8'sd10;
      3'h3: t = 8'sd15;
      3'h4: t = 8'sd40;
      3'h5: t = 8'sd45;
      3'h6: t = 8'sd50;
      default: t = 8'sd60;
    endcase
    return t;
  endfunction
endpackage
`default_nettype wire

// >>> verilog/wbc_decode.sv
`default_nettype none
module wbc_decode
  import wbc_pkg::*;
(
  input wire logic [7:0] config_i,
  input wire logic [2:0] second_code_i,
  output wbc_pkg::wbc_band_t band_o
);
  wbc_fields_t f;
  assign f = wbc_fields_t'(config_i);
  always_comb begin
    band_o.upper_temp_c = wbc_temp_decode(f.third_temp_threshold_select);
    band_o.lower_temp_c = wbc_temp_decode(second_code_i);
    unique case (f.mid_band_term_voltage_select)
      2'h0: band_o.term_voltage_mv = 12'd2000;
      2'h1: band_o.term_voltage_mv = 12'd2050;
      2'h2: band_o.term_voltage_mv = 12'd2075;
      2'h3: band_o.term_voltage_mv = 12'd2100;
    endcase
    unique case (f.mid_band_charge_current_select)
      3'h0: band_o.current_permille = 10'd0;
      3'h1: band_o.current_permille = 10'd250;
      3'h2: band_o.current_permille = 10'd375;
      3'h3: band_o.current_permille = 10'd500;
      3'h4: band_o.current_permille = 10'd625;
      3'h5: band_o.current_permille = 10'd750;
      3'h6: band_o.current_permille = 10'd875;
      3'h7: band_o.current_permille = 10'd1000;
    endcase
  end
endmodule
`default_nettype wire

// >>> verilog/wbc_config_reg.sv
`default_nettype none
module wbc_config_reg
  import wbc_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [7:0] addr_i,
  input wire logic wr_en_i,
  input wire logic [7:0] wr_data_i,
  input wire logic [7:0] second_threshold_i,
  output logic [7:0] rd_data_o,
  output logic [7:0] config_o,
  output wbc_pkg::wbc_band_t band_o
);
  logic [7:0] config_reg, config_next;
  logic [7:0] rd_reg, rd_next;
  wbc_band_t band_comb;
  wbc_band_t band_reg;

  always_comb begin
    config_next = config_reg;
    if (wr_en_i && addr_i == WBC_CONFIG_OFFSET) begin
      config_next = wr_data_i;
    end
  end

  always_comb begin
    rd_next = 8'h00;
    if (addr_i == WBC_CONFIG_OFFSET) begin
      rd_next = config_next;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      config_reg <= WBC_CONFIG_RESET;
      rd_reg <= 8'h00;
    end else begin
      config_reg <= config_next;
      rd_reg <= rd_next;
    end
  end

  wbc_decode u_decode (
    .config_i(config_reg),
    .second_code_i(second_threshold_i[WBC_TEMP_MSB:WBC_TEMP_LSB]),
    .band_o(band_comb)
  );

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      band_reg <= '0;
    end else begin
      band_reg <= band_comb;
    end
  end

  assign rd_data_o = rd_reg;
  assign config_o = config_reg;
  assign band_o = band_reg;

  a_write_lands: assert property (
    @(posedge clock_i) disable iff (rst_i)
    wr_en_i && addr_i == WBC_CONFIG_OFFSET |=> config_o == $past(wr_data_i))
    else $error("write not stored");
  a_hold_value: assert property (
    @(posedge clock_i) disable iff (rst_i)
    !(wr_en_i && addr_i == WBC_CONFIG_OFFSET) |=> $stable(config_o))
    else $error("config changed without write");
  a_read_back: assert property (
    @(posedge clock_i) disable iff (rst_i)
    addr_i == WBC_CONFIG_OFFSET && !wr_en_i |=> rd_data_o == config_o)
    else $error("readback mismatch");
  a_write_through: assert property (
    @(posedge clock_i) disable iff (rst_i)
    wr_en_i && addr_i == WBC_CONFIG_OFFSET |=> rd_data_o == $past(wr_data_i))
    else $error("read during write not new value");
  a_unmapped_read: assert property (
    @(posedge clock_i) disable iff (rst_i)
    addr_i != WBC_CONFIG_OFFSET |=> rd_data_o == 8'h00)
    else $error("unmapped read not zero");
  a_reset_value: assert property (
    @(posedge clock_i)
    rst_i |=> config_o == WBC_CONFIG_RESET)
    else $error("reset value wrong");
  a_reset_read: assert property (
    @(posedge clock_i)
    rst_i |=> rd_data_o == 8'h00)
    else $error("read data not cleared by reset");
  a_reset_band: assert property (
    @(posedge clock_i)
    rst_i |=> band_o == '0)
    else $error("band not cleared by reset");

  a_temp_top: assert property (
    @(posedge clock_i) disable iff (rst_i)
    config_o[WBC_TEMP_MSB:WBC_TEMP_LSB] == 3'h7 |=> band_o.upper_temp_c == 8'sd60)
    else $error("temp decode wrong");
  a_upper_code0: assert property (
    @(posedge clock_i) disable iff (rst_i)
    config_o[WBC_TEMP_MSB:WBC_TEMP_LSB] == 3'h0 |=> band_o.upper_temp_c == -8'sd10)
    else $error("upper edge code 0 wrong");
  a_upper_code1: assert property (
    @(posedge clock_i) disable iff (rst_i)
    config_o[WBC_TEMP_MSB:WBC_TEMP_LSB] == 3'h1 |=> band_o.upper_temp_c == 8'sd0)
    else $error("upper edge code 1 wrong");
  a_upper_code2: assert property (
    @(posedge clock_i) disable iff (rst_i)
    config_o[WBC_TEMP_MSB:WBC_TEMP_LSB] == 3'h2 |=> band_o.upper_temp_c == 8'sd10)
    else $error("upper edge code 2 wrong");
  a_upper_code3: assert property (
    @(posedge clock_i) disable iff (rst_i)
    config_o[WBC_TEMP_MSB:WBC_TEMP_LSB] == 3'h3 |=> band_o.upper_temp_c == 8'sd15)
    else $error("upper edge code 3 wrong");
  a_upper_code4: assert property (
    @(posedge clock_i) disable iff (rst_i)
    config_o[WBC_TEMP_MSB:WBC_TEMP_LSB] == 3'h4 |=> band_o.upper_temp_c == 8'sd40)
    else $error("upper edge code 4 wrong");
  a_upper_code5: assert property (
    @(posedge clock_i) disable iff (rst_i)
    config_o[WBC_TEMP_MSB:WBC_TEMP_LSB] == 3'h5 |=> band_o.upper_temp_c == 8'sd45)
    else $error("upper edge code 5 wrong");
  a_upper_code6: assert property (
    @(posedge clock_i) disable iff (rst_i)
    config_o[WBC_TEMP_MSB:WBC_TEMP_LSB] == 3'h6 |=> band_o.upper_temp_c == 8'sd50)
    else $error("upper edge code 6 wrong");

  a_volt_low: assert property (
    @(posedge clock_i) disable iff (rst_i)
    config_o[WBC_VOLT_MSB:WBC_VOLT_LSB] == 2'h0 |=> band_o.term_voltage_mv == 12'd2000)
    else $error("voltage decode wrong");
  a_volt_code1: assert property (
    @(posedge clock_i) disable iff (rst_i)
    config_o[WBC_VOLT_MSB:WBC_VOLT_LSB] == 2'h1 |=> band_o.term_voltage_mv == 12'd2050)
    else $error("voltage code 1 wrong");
  a_volt_code2: assert property (
    @(posedge clock_i) disable iff (rst_i)
    config_o[WBC_VOLT_MSB:WBC_VOLT_LSB] == 2'h2 |=> band_o.term_voltage_mv == 12'd2075)
    else $error("voltage code 2 wrong");
  a_volt_code3: assert property (
    @(posedge clock_i) disable iff (rst_i)
    config_o[WBC_VOLT_MSB:WBC_VOLT_LSB] == 2'h3 |=> band_o.term_voltage_mv == 12'd2100)
    else $error("voltage code 3 wrong");

  a_curr_full: assert property (
    @(posedge clock_i) disable iff (rst_i)
    config_o[WBC_CURR_MSB:WBC_CURR_LSB] == 3'h7 |=> band_o.current_permille == 10'd1000)
    else $error("current decode wrong");
  a_curr_code0: assert property (
    @(posedge clock_i) disable iff (rst_i)
    config_o[WBC_CURR_MSB:WBC_CURR_LSB] == 3'h0 |=> band_o.current_permille == 10'd0)
    else $error("current code 0 wrong");
  a_curr_code1: assert property (
    @(posedge clock_i) disable iff (rst_i)
    config_o[WBC_CURR_MSB:WBC_CURR_LSB] == 3'h1 |=> band_o.current_permille == 10'd250)
    else $error("current code 1 wrong");
  a_curr_code2: assert property (
    @(posedge clock_i) disable iff (rst_i)
    config_o[WBC_CURR_MSB:WBC_CURR_LSB] == 3'h2 |=> band_o.current_permille == 10'd375)
    else $error("current code 2 wrong");
  a_curr_code3: assert property (
    @(posedge clock_i) disable iff (rst_i)
    config_o[WBC_CURR_MSB:WBC_CURR_LSB] == 3'h3 |=> band_o.current_permille == 10'd500)
    else $error("current code 3 wrong");
  a_curr_code4: assert property (
    @(posedge clock_i) disable iff (rst_i)
    config_o[WBC_CURR_MSB:WBC_CURR_LSB] == 3'h4 |=> band_o.current_permille == 10'd625)
    else $error("current code 4 wrong");
  a_curr_code5: assert property (
    @(posedge clock_i) disable iff (rst_i)
    config_o[WBC_CURR_MSB:WBC_CURR_LSB] == 3'h5 |=> band_o.current_permille == 10'd750)
    else $error("current code 5 wrong");
  a_curr_code6: assert property (
    @(posedge clock_i) disable iff (rst_i)
    config_o[WBC_CURR_MSB:WBC_CURR_LSB] == 3'h6 |=> band_o.current_permille == 10'd875)
    else $error("current code 6 wrong");

  a_lower_edge: assert property (
    @(posedge clock_i) disable iff (rst_i)
    second_threshold_i[WBC_TEMP_MSB:WBC_TEMP_LSB] == 3'h0 |=> band_o.lower_temp_c == -8'sd10)
    else $error("lower edge wrong");
  a_lower_code1: assert property (
    @(posedge clock_i) disable iff (rst_i)
    second_threshold_i[WBC_TEMP_MSB:WBC_TEMP_LSB] == 3'h1 |=> band_o.lower_temp_c == 8'sd0)
    else $error("lower edge code 1 wrong");
  a_lower_code2: assert property (
    @(posedge clock_i) disable iff (rst_i)
    second_threshold_i[WBC_TEMP_MSB:WBC_TEMP_LSB] == 3'h2 |=> band_o.lower_temp_c == 8'sd10)
    else $error("lower edge code 2 wrong");
  a_lower_code3: assert property (
    @(posedge clock_i) disable iff (rst_i)
    second_threshold_i[WBC_TEMP_MSB:WBC_TEMP_LSB] == 3'h3 |=> band_o.lower_temp_c == 8'sd15)
    else $error("lower edge code 3 wrong");
  a_lower_code4: assert property (
    @(posedge clock_i) disable iff (rst_i)
    second_threshold_i[WBC_TEMP_MSB:WBC_TEMP_LSB] == 3'h4 |=> band_o.lower_temp_c == 8'sd40)
    else $error("lower edge code 4 wrong");
  a_lower_code5: assert property (
    @(posedge clock_i) disable iff (rst_i)
    second_threshold_i[WBC_TEMP_MSB:WBC_TEMP_LSB] == 3'h5 |=> band_o.lower_temp_c == 8'sd45)
    else $error("lower edge code 5 wrong");
  a_lower_code6: assert property (
    @(posedge clock_i) disable iff (rst_i)
    second_threshold_i[WBC_TEMP_MSB:WBC_TEMP_LSB] == 3'h6 |=> band_o.lower_temp_c == 8'sd50)
    else $error("lower edge code 6 wrong");
  a_lower_code7: assert property (
    @(posedge clock_i) disable iff (rst_i)
    second_threshold_i[WBC_TEMP_MSB:WBC_TEMP_LSB] == 3'h7 |=> band_o.lower_temp_c == 8'sd60)
    else $error("lower edge code 7 wrong");
endmodule
`default_nettype wire

// >>> dv/wbc_host_model.sv
`default_nettype none
module wbc_host_model (
  input wire logic clock_i,
  output logic [7:0] addr_o,
  output logic wr_en_o,
  output logic [7:0] wr_data_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    addr_o = 8'h00;
    wr_en_o = 1'b0;
    wr_data_o = 8'h00;
  end
  // one access: returns once read data has landed
  task automatic access(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(negedge clock_i);
    addr_o = a;
    wr_en_o = w;
    wr_data_o = d;
    @(negedge clock_i);
    wr_en_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// >>> dv/tb_wbc_config_reg.sv
`default_nettype none
module tb_wbc_config_reg;
  timeunit 1ns;
  timeprecision 1ps;
  import wbc_pkg::*;
  logic clock_i = 1'b0, rst_i = 1'b1;
  logic [7:0] addr, wr_data, second = 8'h4B, rd_data, config_q;
  logic wr_en;
  wbc_band_t band;
  int num_errors = 0, checked = 0, cycles = 0;
  int tmp[8] = '{-10, 0, 10, 15, 40, 45, 50, 60};
  int mv[4] = '{2000, 2050, 2075, 2100};
  int pm[8] = '{0, 250, 375, 500, 625, 750, 875, 1000};
  wbc_host_model wbc_host_model_i (.clock_i(clock_i), .addr_o(addr), .wr_en_o(wr_en),
    .wr_data_o(wr_data));
  wbc_config_reg wbc_config_reg_i (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr),
    .wr_en_i(wr_en), .wr_data_i(wr_data), .second_threshold_i(second), .rd_data_o(rd_data),
    .config_o(config_q), .band_o(band));
  initial begin
    forever #12.5 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles > 2000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic check_band(input int t, input int l, input int v, input int c);
    chk({24'h000000, band.upper_temp_c}, {24'h000000, 8'(tmp[t])});
    chk({24'h000000, band.lower_temp_c}, {24'h000000, 8'(tmp[l])});
    chk(band.term_voltage_mv, mv[v]);
    chk(band.current_permille, pm[c]);
  endtask
  task automatic test_reset();
    wbc_host_model_i.access(8'h07, 1'b0, 8'h00);
    chk(rd_data, 8'hBF);
    chk(config_q, 8'hBF);
    check_band(5, 2, 3, 7);
  endtask
  task automatic test_codes();
    logic [7:0] d;
    for (int i = 0; i < 8; i++) begin
      d = {i[2:0], i[1:0], i[2:0]};
      second = {3'(7 - i), 5'h00};
      wbc_host_model_i.access(8'h07, 1'b1, d);
      chk(rd_data, d);
      @(negedge clock_i);
      check_band(i, 7 - i, i % 4, i);
    end
  endtask
  task automatic test_unmapped();
    wbc_host_model_i.access(8'h06, 1'b1, 8'h00);
    chk(rd_data, 8'h00);
    chk(config_q, 8'hFF);
    wbc_host_model_i.access(8'h07, 1'b0, 8'h00);
    chk(rd_data, 8'hFF);
  endtask
  task automatic test_mid_reset();
    @(negedge clock_i);
    rst_i = 1'b1;
    second = WBC_SECOND_RESET;
    repeat (2) @(negedge clock_i);
    chk(config_q, WBC_CONFIG_RESET);
    chk(rd_data, 8'h00);
    rst_i = 1'b0;
    wbc_host_model_i.access(8'h07, 1'b1, 8'h5A);
    chk(rd_data, 8'h5A);
    chk(config_q, 8'h5A);
    @(negedge clock_i);
    check_band(2, 2, 3, 2);
  endtask
  task automatic report_and_stop();
    if (num_errors == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (20) @(negedge clock_i);
    rst_i = 1'b0;
    test_reset();
    test_codes();
    test_unmapped();
    test_mid_reset();
    report_and_stop();
  end
endmodule
`default_nettype wire
